// ===== verification/regfile_model.sv
// behavioural register file answering the execution block
`timescale 1ns/10ps
`default_nettype none
module regfile_model (
    // clock
    input wire logic        sys_clk,
    // access from the block
    input wire logic [11:0] file_addr,
    input wire logic        file_rd,
    input wire logic        file_we,
    input wire logic [7:0]  file_wdata,
    output logic     [7:0]  file_rdata
);
    logic [7:0] mem [4096];
    // data valid one phase after the read, garbage otherwise
    always @(posedge sys_clk) begin
        if (file_rd) begin
            file_rdata <= mem[file_addr];
        end else begin
            file_rdata <= file_addr[7:0] ^ 8'ha5;
        end
        if (file_we) begin
            mem[file_addr] <= file_wdata;
        end
    end
endmodule : regfile_model
`default_nettype wire

// ===== verification/subexec_core_properties.sv
// port-level checks of the subtract and branch execution block
`timescale 1ns/10ps
`default_nettype none
module subexec_props #(parameter int PC_W = 21) (
    // clock and reset
    input wire logic            sys_clk,
    input wire logic            rst,
    // instruction side
    input wire logic [15:0]     instr,
    input wire logic            instr_taken,
    input wire logic            ready,
    input wire logic [PC_W-1:0] pc,
    // register file side
    input wire logic [3:0]      bank_select_reg,
    input wire logic [11:0]     file_addr,
    input wire logic            file_rd,
    input wire logic [7:0]      file_rdata,
    input wire logic            file_we,
    input wire logic [7:0]      file_wdata,
    // core state
    input wire logic [7:0]      acc,
    input wire logic [subexec_pkg::FLAG_W-1:0] flags
);
    import subexec_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [PC_W-1:0] br_step;
    wire logic lit_go = instr_taken && instr[15:8] == LIT_SUB_OPC;
    wire logic file_go = instr_taken && instr[15:10] == FILE_SUB_OPC;
    wire logic br_go = instr_taken && instr[15:8] == BR_NZ_OPC;
    always_ff @(posedge sys_clk) begin
        if (br_go) begin
            br_step <= PC_W'(signed'({instr[7:0], 1'b0})) + PC_W'(2);
        end
    end
    sequence nop_cycle;
        !ready [*4] ##1 ready;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    AST_LIT_RESULT: assert property (
        lit_go |-> ##4 acc == $past(instr[7:0], 4) - $past(acc, 4))
        else $error("literal subtract result wrong");
    AST_FILE_BACK: assert property (
        file_go && instr[DEST_BIT] |-> ##4 file_we
        && file_wdata == $past(file_rdata, 2) - $past(acc, 4))
        else $error("file write-back wrong");
    AST_FILE_ACC: assert property (
        file_go && !instr[DEST_BIT] |-> ##4 !file_we
        && acc == $past(file_rdata, 2) - $past(acc, 4))
        else $error("file difference not in accumulator");
    AST_BANKED_ADDR: assert property (
        file_go && instr[ACCESS_BIT] |=> file_rd
        && file_addr == {$past(bank_select_reg), $past(instr[7:0])})
        else $error("banked file address wrong");
    AST_BR_TAKEN: assert property (
        br_go && !flags[FLAG_Z] |-> ##4 pc == $past(pc, 4) + br_step
        ##0 nop_cycle)
        else $error("taken branch target or idle cycle wrong");
    AST_BR_NOT_TAKEN: assert property (
        br_go && flags[FLAG_Z] |-> ##4 ready
        && pc == $past(pc, 4) + PC_W'(2) ##1 ready [*3])
        else $error("untaken branch wrong");
    AST_LIT_FLAGS: assert property (
        lit_go |-> ##4 flags[FLAG_Z] == (acc == 8'h00)
        && flags[FLAG_N] == acc[7]
        && flags[FLAG_C] == ($past(instr[7:0], 4) >= $past(acc, 4)))
        else $error("subtract flags wrong");
endmodule : subexec_props
bind subexec_core subexec_props #(.PC_W(PC_W)) subexec_props_i (
    .sys_clk, .rst, .instr, .instr_taken, .ready, .pc, .bank_select_reg,
    .file_addr, .file_rd, .file_rdata, .file_we, .file_wdata, .acc, .flags);
`default_nettype wire

// ===== verification/test_subexec_core.sv
// self-checking bench for the subtract and branch execution block
`timescale 1ns/10ps
`default_nettype none
module test_subexec_core;
    import subexec_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1, instr_valid = 1'b0;
    logic reg_we = 1'b0, reg_re = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic [3:0] bank_select_reg = 4'h3;
    logic [11:0] index_base = 12'h400, file_addr;
    logic [1:0] reg_addr = 2'h0, phase;
    logic [7:0] reg_wdata = 8'h00, file_rdata, file_wdata, acc, reg_rdata;
    logic [20:0] pc, exp_pc = 21'h0;
    logic [4:0] flags, exp_flags = 5'h00;
    logic [7:0] exp_acc = 8'h00;
    logic instr_taken, ready, file_rd, file_we;
    int num_errors = 0, checks = 0;
    subexec_core subexec_core_i (.sys_clk, .rst, .instr, .instr_valid,
        .instr_taken, .ready, .pc, .phase, .bank_select_reg, .index_base,
        .file_addr, .file_rd, .file_rdata, .file_we, .file_wdata, .acc,
        .flags, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata);
    regfile_model regfile_model_i (.sys_clk, .file_addr, .file_rd,
        .file_we, .file_wdata, .file_rdata);
    always #20 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [4:0] fl(input logic [7:0] m,
                                      input logic [7:0] s);
        logic [7:0] r;
        r = m - s;
        return {r[7], m[7] != s[7] && r[7] != m[7], r == 8'h00,
            m[3:0] >= s[3:0], m >= s};
    endfunction : fl
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge sys_clk);
        reg_we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge sys_clk);
        reg_re <= 1'b0;
        @(negedge sys_clk);
        chk(reg_rdata, exp);
    endtask : rd
    task automatic issue(input logic [15:0] w, input logic [20:0] ofs);
        int n;
        n = 0;
        @(posedge sys_clk);
        instr <= w;
        instr_valid <= 1'b1;
        do begin
            @(negedge sys_clk);
            n++;
        end while (instr_taken !== 1'b1 && n < 40);
        chk(instr_taken, 21'h1);
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        exp_pc = exp_pc + 21'd2 + ofs;
        chk(phase, PH_Q1);
        chk(pc, exp_pc);
        chk(acc, exp_acc);
        chk(flags, exp_flags);
    endtask : issue
    task automatic lit(input logic [7:0] k);
        exp_flags = fl(k, exp_acc);
        exp_acc = k - exp_acc;
        issue({LIT_SUB_OPC, k}, 21'h0);
    endtask : lit
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rd(CTRL_OFS, {7'h00, EXT_RESET});
        rd(FLAGS_OFS, {3'h0, FLAG_RESET});
        wr(ACC_OFS, 8'h5a);
        rd(ACC_OFS, ACC_RESET);
        wr(2'h3, 8'hff);
        rd(2'h3, 8'h00);
        $display("register port test done");
    endtask : t_regs
    task automatic t_lit;
        logic [7:0] ks [5] = '{8'h02, 8'h02, 8'h80, 8'h7f, 8'h00};
        foreach (ks[i]) begin
            lit(ks[i]);
        end
        $display("literal subtract test done");
    endtask : t_lit
    task automatic t_file;
        logic [10:0] cs [5] = '{{3'b011, 8'h23}, {3'b000, 8'h7f},
            {3'b010, 8'h80}, {3'b110, 8'h5f}, {3'b100, 8'h60}};
        logic [11:0] ad [5] = '{12'h323, 12'h07f, 12'hf80, 12'h45f, 12'h060};
        logic [7:0] v, wd;
        foreach (cs[i]) begin
            v = 8'h41 + 8'(i) * 8'h13;
            regfile_model_i.mem[ad[i]] = v;
            wr(CTRL_OFS, {7'h00, cs[i][10]});
            rd(CTRL_OFS, {7'h00, cs[i][10]});
            exp_flags = fl(v, exp_acc);
            wd = v - exp_acc;
            if (!cs[i][9]) begin
                exp_acc = wd;
            end
            issue({FILE_SUB_OPC, cs[i][9:0]}, 21'h0);
            chk(file_we, cs[i][9]);
            if (cs[i][9]) begin
                chk(file_wdata, wd);
            end
        end
        rd(FLAGS_OFS, {3'h0, exp_flags});
        rd(ACC_OFS, exp_acc);
        $display("file subtract test done");
    endtask : t_file
    task automatic t_br;
        logic [7:0] ns [3] = '{8'hfd, 8'h7f, 8'h80};
        lit(exp_acc);
        issue({BR_NZ_OPC, 8'h10}, 21'h0);
        chk(ready, 1'b1);
        foreach (ns[i]) begin
            lit(exp_acc + 8'h01);
            issue({BR_NZ_OPC, ns[i]}, {{12{ns[i][7]}}, ns[i], 1'b0});
            repeat (4) begin
                chk(ready, 1'b0);
                @(negedge sys_clk);
            end
            chk(ready, 1'b1);
        end
        $display("branch test done");
    endtask : t_br
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs;
        t_lit;
        t_file;
        t_br;
        report_and_stop;
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        num_errors++;
        report_and_stop;
    end
endmodule : test_subexec_core
`default_nettype wire

// ===== verilog/sub8_unit.sv
// eight-bit two's-complement subtractor with arithmetic flags
`timescale 1ns/10ps
`default_nettype none

module sub8_unit (
    // operands
    input  wire logic [7:0] minuend,
    input  wire logic [7:0] subtrahend,
    // result
    output logic      [7:0] diff,
    output logic            no_borrow,
    output logic            digit_no_borrow,
    output logic            overflow,
    output logic            zero,
    output logic            negative
);
    logic [8:0] full_sum;
    logic [4:0] low_sum;

    always_comb begin
        full_sum        = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
        low_sum         = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]}
                          + 5'h01;
        diff            = full_sum[7:0];
        no_borrow       = full_sum[8];
        digit_no_borrow = low_sum[4];
        overflow        = (minuend[7] != subtrahend[7])
                          && (full_sum[7] != minuend[7]);
        zero            = (full_sum[7:0] == 8'h00);
        negative        = full_sum[7];
    end

endmodule : sub8_unit

`default_nettype wire

// ===== verilog/subexec_core.sv
// execution datapath for literal/file subtract and branch on nonzero
// How it works
// RULE_01 - opcode 0000 1000: accumulator gets literal minus accumulator
// RULE_02 - opcode 0101 11da: file register minus accumulator
// RULE_03 - destination bit zero writes accumulator, one writes file register
// RULE_04 - access bit zero: access bank, one: bank select; indexed to 5Fh
// RULE_05 - taken branch: decode, read, process, write pc, then one idle cycle
// RULE_06 - zero set: no branch, one cycle, pc becomes address plus two
// RULE_07 - subtracts set all five flags; carry set when no borrow
`timescale 1ns/10ps
`default_nettype none

module subexec_core #(
    parameter int PC_W = 21
) (
    // clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    // instruction from decoder
    input  wire logic [15:0]                instr,
    input  wire logic                       instr_valid,
    output logic                            instr_taken,
    output logic                            ready,
    output logic [PC_W-1:0]                 pc,
    output logic [1:0]                      phase,
    // register file side
    input  wire logic [3:0]                 bank_select_reg,
    input  wire logic [11:0]                index_base,
    output logic [11:0]                     file_addr,
    output logic                            file_rd,
    input  wire logic [7:0]                 file_rdata,
    output logic                            file_we,
    output logic [7:0]                      file_wdata,
    // core state
    output logic [7:0]                      acc,
    output logic [subexec_pkg::FLAG_W-1:0]  flags,
    // software port
    input  wire logic [1:0]                 reg_addr,
    input  wire logic [7:0]                 reg_wdata,
    input  wire logic                       reg_we,
    input  wire logic                       reg_re,
    output logic [7:0]                      reg_rdata
);
    import subexec_pkg::*;

    if (PC_W < 9 || PC_W > 32) begin : g_bad_pc_w
        $error("PC_W must lie between 9 and 32");
    end

    ////////////////////////////////////////////////////////////////////////
    // state
    exec_op_t         op, next_op;
    cycle_t           cyc, next_cyc;
    logic [1:0]       next_phase;
    logic [15:0]      word, next_word;
    logic [7:0]       operand, next_operand;
    logic             take_br, next_take_br;
    logic [PC_W-1:0]  next_pc;
    logic [11:0]      next_file_addr;
    logic             next_file_rd;
    logic             next_file_we;
    logic [7:0]       next_file_wdata;
    logic [7:0]       next_acc;
    logic [4:0]       next_flags;
    logic             ext_en, next_ext_en;
    logic [7:0]       next_reg_rdata;

    logic [7:0]       diff;
    logic             s_c, s_hc, s_vf, s_z, s_n;
    logic [PC_W-1:0]  pc_plus2;
    logic [PC_W-1:0]  br_target;
    logic [11:0]      dec_addr;

    sub8_unit u_sub (
        .minuend         (operand),
        .subtrahend      (acc),
        .diff            (diff),
        .no_borrow       (s_c),
        .digit_no_borrow (s_hc),
        .overflow        (s_vf),
        .zero            (s_z),
        .negative        (s_n)
    );

    assign instr_taken = (phase == PH_Q1) && (cyc == CYC_EXEC) && instr_valid;
    assign ready       = (cyc == CYC_EXEC);
    assign pc_plus2    = pc + PC_W'(2);
    assign br_target   = pc_plus2
                         + PC_W'({{(PC_W-9){word[7]}}, word[7:0], 1'b0});

    ////////////////////////////////////////////////////////////////////////
    // data address resolution
    always_comb begin
        if (instr[ACCESS_BIT]) begin
            dec_addr = {bank_select_reg, instr[7:0]};              // RULE_04
        end else if (ext_en && instr[7:0] <= INDEXED_LIMIT) begin
            dec_addr = index_base + {4'h0, instr[7:0]};            // RULE_04
        end else if (instr[7:0] < ACCESS_SPLIT) begin
            dec_addr = {ACCESS_LO_BNK, instr[7:0]};                // RULE_04
        end else begin
            dec_addr = {ACCESS_HI_BNK, instr[7:0]};                // RULE_04
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // instruction sequencing
    always_comb begin
        next_phase      = phase + 2'h1;
        next_op         = op;
        next_cyc        = cyc;
        next_word       = word;
        next_operand    = operand;
        next_take_br    = take_br;
        next_pc         = pc;
        next_file_addr  = file_addr;
        next_file_rd    = 1'b0;
        next_file_we    = 1'b0;
        next_file_wdata = file_wdata;
        next_acc        = acc;
        next_flags      = flags;
        case (phase)
            PH_Q1: begin
                next_op      = OP_NONE;
                next_take_br = 1'b0;
                if (instr_taken) begin
                    next_word = instr;
                    if (instr[15:8] == LIT_SUB_OPC) begin
                        next_op = OP_LIT_SUB;                      // RULE_01
                    end else if (instr[15:10] == FILE_SUB_OPC) begin
                        next_op        = OP_FILE_SUB;              // RULE_02
                        next_file_addr = dec_addr;
                        next_file_rd   = 1'b1;
                    end else if (instr[15:8] == BR_NZ_OPC) begin
                        next_op = OP_BRANCH_NZ;
                    end
                end
            end
            PH_Q2: begin
                if (op == OP_LIT_SUB || op == OP_BRANCH_NZ) begin
                    next_operand = word[7:0];
                end
            end
            PH_Q3: begin
                if (op == OP_FILE_SUB) begin
                    next_operand = file_rdata;
                end
                if (op == OP_BRANCH_NZ) begin
                    next_take_br = ~flags[FLAG_Z];                 // RULE_05
                end
            end
            PH_Q4: begin
                if (cyc == CYC_FLUSH) begin
                    next_cyc = CYC_EXEC;                           // RULE_05
                end else if (op != OP_NONE) begin
                    next_pc = take_br ? br_target : pc_plus2;      // RULE_06
                    if (take_br) begin
                        next_cyc = CYC_FLUSH;                      // RULE_05
                    end
                end
            end
            default: begin
                next_op = OP_NONE;
            end
        endcase
        // write back in Q4 from the operand latched at Q2 or Q3
        if (phase == PH_Q4 && (op == OP_LIT_SUB || op == OP_FILE_SUB)) begin
            next_flags     = {s_n, s_vf, s_z, s_hc, s_c};         // RULE_07
            if (op == OP_FILE_SUB && word[DEST_BIT]) begin
                next_file_we    = 1'b1;                            // RULE_03
                next_file_wdata = diff;                            // RULE_02
            end else begin
                next_acc = diff;                                   // RULE_01
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            phase      <= PH_Q1;
            op         <= OP_NONE;
            cyc        <= CYC_EXEC;
            word       <= 16'h0000;
            operand    <= 8'h00;
            take_br    <= 1'b0;
            pc         <= '0;
            file_addr  <= 12'h000;
            file_rd    <= 1'b0;
            file_we    <= 1'b0;
            file_wdata <= 8'h00;
            acc        <= ACC_RESET;
            flags      <= FLAG_RESET;
        end else begin
            phase      <= next_phase;
            op         <= next_op;
            cyc        <= next_cyc;
            word       <= next_word;
            operand    <= next_operand;
            take_br    <= next_take_br;
            pc         <= next_pc;
            file_addr  <= next_file_addr;
            file_rd    <= next_file_rd;
            file_we    <= next_file_we;
            file_wdata <= next_file_wdata;
            acc        <= next_acc;
            flags      <= next_flags;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software port
    always_comb begin
        next_ext_en    = ext_en;
        next_reg_rdata = 8'h00;
        if (reg_we && reg_addr == CTRL_OFS) begin
            next_ext_en = reg_wdata[0];
        end
        if (reg_re) begin
            case (reg_addr)
                CTRL_OFS:  next_reg_rdata = {7'h00, ext_en};
                FLAGS_OFS: next_reg_rdata = {3'h0, flags};
                ACC_OFS:   next_reg_rdata = acc;
                default:   next_reg_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ext_en    <= EXT_RESET;
            reg_rdata <= 8'h00;
        end else begin
            ext_en    <= next_ext_en;
            reg_rdata <= next_reg_rdata;
        end
    end

endmodule : subexec_core

`default_nettype wire

// ===== verilog/subexec_pkg.sv
// shared constants and types for the subtract and branch execution block
package subexec_pkg;

    ////////////////////////////////////////////////////////////////////////
    // instruction phases, one sys_clk cycle each
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q3 = 2'h2;
    localparam logic [1:0] PH_Q4 = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // opcode fields
    localparam logic [7:0] LIT_SUB_OPC   = 8'h08;
    localparam logic [5:0] FILE_SUB_OPC  = 6'h17;
    localparam logic [7:0] BR_NZ_OPC     = 8'he1;
    localparam int         DEST_BIT      = 9;
    localparam int         ACCESS_BIT    = 8;

    ////////////////////////////////////////////////////////////////////////
    // data address mapping
    localparam logic [7:0] ACCESS_SPLIT  = 8'h80;
    localparam logic [3:0] ACCESS_LO_BNK = 4'h0;
    localparam logic [3:0] ACCESS_HI_BNK = 4'hf;
    localparam logic [7:0] INDEXED_LIMIT = 8'h5f;

    ////////////////////////////////////////////////////////////////////////
    // flag positions in the flag word
    localparam int FLAG_C  = 0;
    localparam int FLAG_HC  = 1;
    localparam int FLAG_Z   = 2;
    localparam int FLAG_OVF = 3;
    localparam int FLAG_N  = 4;
    localparam int FLAG_W  = 5;

    ////////////////////////////////////////////////////////////////////////
    // software port map and reset values
    localparam logic [1:0] CTRL_OFS   = 2'h0;
    localparam logic [1:0] FLAGS_OFS  = 2'h1;
    localparam logic [1:0] ACC_OFS    = 2'h2;
    localparam logic [7:0] ACC_RESET  = 8'h00;
    localparam logic [4:0] FLAG_RESET = 5'h00;
    localparam logic       EXT_RESET  = 1'b0;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_LIT_SUB,
        OP_FILE_SUB,
        OP_BRANCH_NZ
    } exec_op_t;

    typedef enum logic {
        CYC_EXEC,
        CYC_FLUSH
    } cycle_t;

endpackage : subexec_pkg
